// [core/dpsg_defs.vh]
// constants for the display power and sync gating block
`ifndef DPSG_DEFS_VH
`define DPSG_DEFS_VH

// ***********************************
// register byte offsets
// ***********************************
`define DPSG_CTRL_OFF 12'h000
`define DPSG_ROUTE_OFF 12'h004
`define DPSG_STAT_OFF 12'h008
`define DPSG_TIMING_OFF 12'h00c
`define DPSG_PIXDIV_OFF 12'h010

// ***********************************
// control fields
// ***********************************
`define DPSG_CTRL_MON_LSB 0
`define DPSG_CTRL_GFX_BIT 2
`define DPSG_CTRL_RESET 32'h0000_0000

// ***********************************
// route fields: one enable per output, one digital flag per output
// ***********************************
`define DPSG_ROUTE_EN_LSB 0
`define DPSG_ROUTE_DIG_LSB 4
`define DPSG_ROUTE_TV_LSB 8
`define DPSG_ROUTE_RESET 32'h0000_0001
`define DPSG_ROUTE_EN_RESET 4'h1

// ***********************************
// monitor states
// ***********************************
`define DPSG_MON_D0 2'h0
`define DPSG_MON_D1 2'h1
`define DPSG_MON_D2 2'h2
`define DPSG_MON_D3 2'h3

// ***********************************
// timing defaults: horizontal in pixel ticks, vertical in lines, clock rates in MHz
// ***********************************
`define DPSG_HTOTAL_RESET 12'h320
`define DPSG_HSYNC_RESET 12'h060
`define DPSG_VTOTAL_RESET 12'h20d
`define DPSG_VSYNC_RESET 12'h002
`define DPSG_GFX_CLK_MHZ 200
`define DPSG_REF_CLK_MHZ 48
`define DPSG_PIX_MIN_MHZ 12
`define DPSG_PIX_MAX_MHZ 350
`define DPSG_PIXDIV_RESET 16'h0001

`endif

// [core/dpsg_top.v]
// display power state and sync gating block with apb register slave
`timescale 1ns/1ps
`include "dpsg_defs.vh"

module dpsg_top (
  input wire pclk, // apb clock, host side
  input wire presetn, // async reset, active low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [11:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire [31:0] prdata, // apb read data
  output wire pready, // apb ready
  output wire pslverr, // apb error
  input wire display_reference_clock, // 48 MHz reference
  input wire disp_rst_n, // display domain reset, active low
  output reg hsync_out, // horizontal sync
  output reg vsync_out, // vertical sync
  output reg [3:0] out_enable, // per-output enable
  output reg pix_tick // pixel enable pulse
);

  // ***********************************
  // host side registers
  // ***********************************
  reg [1:0] mon_reg;
  reg gfx_d3_reg;
  reg [3:0] route_en_reg;
  reg [3:0] route_dig_reg;
  reg [3:0] route_tv_reg;
  reg [11:0] htotal_reg;
  reg [11:0] hsync_len_reg;
  reg [11:0] vtotal_reg;
  reg [11:0] vsync_len_reg;
  reg [15:0] pixdiv_reg;
  reg route_err_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdata_next;

  wire acc = psel & penable;
  wire wr = acc & pwrite;

  function [2:0] popcount4;
    input [3:0] v;
    begin
      popcount4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
    end
  endfunction

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `DPSG_CTRL_OFF) || (a == `DPSG_ROUTE_OFF) ||
               (a == `DPSG_STAT_OFF) || (a == `DPSG_TIMING_OFF) ||
               (a == `DPSG_PIXDIV_OFF);
    end
  endfunction

  // new route request, checked before it is stored
  wire [3:0] req_en = pwdata[`DPSG_ROUTE_EN_LSB+3:`DPSG_ROUTE_EN_LSB];
  wire [3:0] req_dig = pwdata[`DPSG_ROUTE_DIG_LSB+3:`DPSG_ROUTE_DIG_LSB];
  wire [3:0] req_tv = pwdata[`DPSG_ROUTE_TV_LSB+3:`DPSG_ROUTE_TV_LSB];
  wire [2:0] n_en = popcount4(req_en);
  wire bad_tv = (n_en > 3'h1) && ((req_en & req_tv) != 4'h0);
  wire bad_dig = popcount4(req_en & (req_dig | req_tv)) > 3'h1;
  // one pipe, at most two mirrored outputs
  wire bad_cnt = n_en > 3'h2;
  wire route_bad = bad_tv | bad_dig | bad_cnt;

  assign pready = 1'b1;
  assign pslverr = acc & (~mapped(paddr) | (pwrite & (paddr == `DPSG_ROUTE_OFF) & route_bad));
  assign prdata = rdata_reg;

  // reset puts graphics in D0, monitor D0
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_reg <= `DPSG_MON_D0;
      gfx_d3_reg <= 1'b0;
      route_en_reg <= `DPSG_ROUTE_EN_RESET;
      route_dig_reg <= 4'h0;
      route_tv_reg <= 4'h0;
      htotal_reg <= `DPSG_HTOTAL_RESET;
      hsync_len_reg <= `DPSG_HSYNC_RESET;
      vtotal_reg <= `DPSG_VTOTAL_RESET;
      vsync_len_reg <= `DPSG_VSYNC_RESET;
      pixdiv_reg <= `DPSG_PIXDIV_RESET;
      route_err_reg <= 1'b0;
    end else if (wr) begin
      case (paddr)
        `DPSG_CTRL_OFF: begin
          mon_reg <= pwdata[`DPSG_CTRL_MON_LSB+1:`DPSG_CTRL_MON_LSB];
          gfx_d3_reg <= pwdata[`DPSG_CTRL_GFX_BIT];
        end
        `DPSG_ROUTE_OFF: begin
          // illegal routes are refused, old route kept
          if (route_bad) begin
            route_err_reg <= 1'b1;
          end else begin
            route_en_reg <= req_en;
            route_dig_reg <= req_dig;
            route_tv_reg <= req_tv;
            route_err_reg <= 1'b0;
          end
        end
        `DPSG_TIMING_OFF: begin
          htotal_reg <= pwdata[11:0];
          hsync_len_reg <= {4'h0, pwdata[23:16]};
          vtotal_reg <= vtotal_reg;
        end
        `DPSG_PIXDIV_OFF: begin
          pixdiv_reg <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
          vtotal_reg <= {pwdata[27:16]};
          vsync_len_reg <= {8'h00, pwdata[31:28]};
        end
        default: begin
          route_err_reg <= route_err_reg;
        end
      endcase
    end
  end

  // ***********************************
  // display domain: synchronised settings
  // ***********************************
  reg [1:0] mon_s1_reg;
  reg [1:0] mon_s2_reg;
  reg gfx_s1_reg;
  reg gfx_s2_reg;
  reg [3:0] en_s1_reg;
  reg [3:0] en_s2_reg;
  reg [1:0] mon_live_reg;
  reg gfx_live_reg;
  reg [3:0] en_live_reg;
  reg [15:0] div_cnt_reg;
  reg [11:0] hcnt_reg;
  reg [11:0] vcnt_reg;
  reg [31:0] stat_s1_reg;
  reg [31:0] stat_s2_reg;

  // display logic on its own clock; settings pass two flops
  // quasi-static settings, so per-bit sync is accepted; frame latch hides skew
  always @(posedge display_reference_clock or negedge disp_rst_n) begin
    if (!disp_rst_n) begin
      mon_s1_reg <= `DPSG_MON_D0;
      mon_s2_reg <= `DPSG_MON_D0;
      gfx_s1_reg <= 1'b0;
      gfx_s2_reg <= 1'b0;
      en_s1_reg <= `DPSG_ROUTE_EN_RESET;
      en_s2_reg <= `DPSG_ROUTE_EN_RESET;
    end else begin
      mon_s1_reg <= mon_reg;
      mon_s2_reg <= mon_s1_reg;
      gfx_s1_reg <= gfx_d3_reg;
      gfx_s2_reg <= gfx_s1_reg;
      en_s1_reg <= route_en_reg;
      en_s2_reg <= en_s1_reg;
    end
  end

  // ***********************************
  // display domain: synchronised timing
  // ***********************************
  // timing words pass two flops into the display clock
  // quasi-static words; counters wrap on >=, so a mixed word bends one frame at most
  wire [63:0] tim_host = {pixdiv_reg, vsync_len_reg, vtotal_reg, hsync_len_reg, htotal_reg};
  reg [63:0] tim_s1_reg;
  reg [63:0] tim_s2_reg;

  always @(posedge display_reference_clock or negedge disp_rst_n) begin
    if (!disp_rst_n) begin
      tim_s1_reg <= {`DPSG_PIXDIV_RESET, `DPSG_VSYNC_RESET, `DPSG_VTOTAL_RESET,
        `DPSG_HSYNC_RESET, `DPSG_HTOTAL_RESET};
      tim_s2_reg <= {`DPSG_PIXDIV_RESET, `DPSG_VSYNC_RESET, `DPSG_VTOTAL_RESET,
        `DPSG_HSYNC_RESET, `DPSG_HTOTAL_RESET};
    end else begin
      tim_s1_reg <= tim_host;
      tim_s2_reg <= tim_s1_reg;
    end
  end

  wire [11:0] htotal_d = tim_s2_reg[11:0];
  wire [11:0] hsync_len_d = tim_s2_reg[23:12];
  wire [11:0] vtotal_d = tim_s2_reg[35:24];
  wire [11:0] vsync_len_d = tim_s2_reg[47:36];
  wire [15:0] pixdiv_d = tim_s2_reg[63:48];

  wire div_wrap = (div_cnt_reg >= pixdiv_d - 16'h0001);
  wire h_wrap = (hcnt_reg >= htotal_d - 12'h001);
  wire v_wrap = (vcnt_reg >= vtotal_d - 12'h001);
  wire frame_end = div_wrap & h_wrap & v_wrap;

  // pixel rate is the 48 MHz reference divided down
  always @(posedge display_reference_clock or negedge disp_rst_n) begin
    if (!disp_rst_n) begin
      div_cnt_reg <= 16'h0000;
      pix_tick <= 1'b0;
    end else begin
      div_cnt_reg <= div_wrap ? 16'h0000 : div_cnt_reg + 16'h0001;
      pix_tick <= div_wrap;
    end
  end

  always @(posedge display_reference_clock or negedge disp_rst_n) begin
    if (!disp_rst_n) begin
      hcnt_reg <= 12'h000;
      vcnt_reg <= 12'h000;
      mon_live_reg <= `DPSG_MON_D0;
      gfx_live_reg <= 1'b0;
      en_live_reg <= `DPSG_ROUTE_EN_RESET;
    end else if (div_wrap) begin
      hcnt_reg <= h_wrap ? 12'h000 : hcnt_reg + 12'h001;
      if (h_wrap) begin
        vcnt_reg <= v_wrap ? 12'h000 : vcnt_reg + 12'h001;
      end
      // new power state only at frame boundary
      if (frame_end) begin
        mon_live_reg <= mon_s2_reg;
        gfx_live_reg <= gfx_s2_reg;
        en_live_reg <= en_s2_reg;
      end
    end
  end

  function h_pulses;
    input [1:0] st;
    begin
      h_pulses = (st == `DPSG_MON_D0) || (st == `DPSG_MON_D2);
    end
  endfunction

  function v_pulses;
    input [1:0] st;
    begin
      v_pulses = (st == `DPSG_MON_D0) || (st == `DPSG_MON_D1);
    end
  endfunction

  wire h_on = h_pulses(mon_live_reg);
  wire v_on = v_pulses(mon_live_reg);

  always @(posedge display_reference_clock or negedge disp_rst_n) begin
    if (!disp_rst_n) begin
      hsync_out <= 1'b0;
      vsync_out <= 1'b0;
      out_enable <= 4'h0;
    end else begin
      // D0 both; D1 vertical; D2 horizontal; D3 none
      // graphics D3 silences both syncs and all outputs
      hsync_out <= h_on & ~gfx_live_reg & (hcnt_reg < hsync_len_d);
      vsync_out <= v_on & ~gfx_live_reg & (vcnt_reg < vsync_len_d);
      out_enable <= gfx_live_reg ? 4'h0 : en_live_reg;
    end
  end

  // ***********************************
  // status back to host, two flops
  // ***********************************
  wire [31:0] stat_disp = {24'h0, 1'b0, gfx_live_reg, mon_live_reg, en_live_reg};
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_s1_reg <= 32'h0000_0000;
      stat_s2_reg <= 32'h0000_0000;
    end else begin
      stat_s1_reg <= stat_disp;
      stat_s2_reg <= stat_s1_reg;
    end
  end

  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `DPSG_CTRL_OFF: rdata_next = {29'h0, gfx_d3_reg, mon_reg};
      `DPSG_ROUTE_OFF: rdata_next = {20'h0, route_tv_reg, route_dig_reg, route_en_reg};
      `DPSG_STAT_OFF: rdata_next = {stat_s2_reg[31:9], route_err_reg, stat_s2_reg[7:0]};
      `DPSG_TIMING_OFF: rdata_next = {8'h00, hsync_len_reg[7:0], 4'h0, htotal_reg};
      `DPSG_PIXDIV_OFF: rdata_next = {vsync_len_reg[3:0], vtotal_reg, pixdiv_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // read data registered in setup so it is valid in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      rdata_reg <= rdata_next;
    end
  end

endmodule

// [bench/dpsg_props.sv]
// assertion checker for the display power and sync gating block
`timescale 1ns/1ps
`include "dpsg_defs.vh"
module dpsg_props (
  input wire pclk, // apb clock
  input wire presetn, // apb reset
  input wire psel, // select
  input wire penable, // enable
  input wire pwrite, // direction
  input wire [11:0] paddr, // address
  input wire [31:0] pwdata, // write data
  input wire [31:0] prdata, // read data
  input wire pready, // ready
  input wire pslverr, // error
  input wire display_reference_clock, // display clock
  input wire disp_rst_n, // display reset
  input wire hsync_out, // hsync
  input wire vsync_out, // vsync
  input wire [3:0] out_enable, // enables
  input wire pix_tick // pixel tick
);
  wire acc = psel && penable;
  wire rw = acc && pwrite && paddr == `DPSG_ROUTE_OFF;
  wire [3:0] en = pwdata[3:0];
  wire [3:0] fl = pwdata[7:4] | pwdata[11:8];
  AST_PREADY: assert property (@(posedge pclk) disable iff (!presetn)
    acc |-> pready) else $error("no ready");
  AST_ERR_ACC: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> acc) else $error("stray error");
  AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
    acc && paddr > `DPSG_PIXDIV_OFF |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access");
  AST_MIRROR_TV: assert property (@(posedge pclk) disable iff (!presetn)
    rw && (en & pwdata[11:8]) != 4'h0 && $countones(en) > 1 |-> pslverr) else $error("tv mirror");
  AST_TWO_DIG: assert property (@(posedge pclk) disable iff (!presetn)
    rw && $countones(en & fl) > 1 |-> pslverr) else $error("two digital");
  AST_THREE: assert property (@(posedge pclk) disable iff (!presetn)
    rw && $countones(en) > 2 |-> pslverr) else $error("three outputs");
  AST_LEGAL: assert property (@(posedge pclk) disable iff (!presetn)
    rw && en == 4'h1 && fl == 4'h0 |-> !pslverr) else $error("legal refused");
  AST_ONE_PIPE: assert property (@(posedge display_reference_clock)
    disable iff (!disp_rst_n) $countones(out_enable) <= 2) else $error("too many outputs");
  AST_DRST: assert property (@(posedge display_reference_clock) disable iff (!presetn)
    !disp_rst_n |-> out_enable == 4'h0 && !hsync_out && !vsync_out) else $error("reset out");
  cover property (@(posedge pclk) acc && pslverr);
  cover property (@(posedge pclk) rw && !pslverr);
  cover property (@(posedge display_reference_clock) $rose(vsync_out));
endmodule
bind dpsg_top dpsg_props u_props (.*);

// [bench/dpsg_mon.sv]
// monitor model counting sync pulses
`timescale 1ns/1ps
module dpsg_mon (
  input wire clk, // reference clock
  input wire clr, // clear counts
  input wire hsync_out, // hsync
  input wire vsync_out, // vsync
  output int hcnt, // hsync pulses
  output int vcnt // vsync pulses
);
  logic h_q = 1'b0;
  logic v_q = 1'b0;
  always @(posedge clk) begin
    h_q <= hsync_out;
    v_q <= vsync_out;
    hcnt <= clr ? 0 : hcnt + int'(hsync_out && !h_q);
    vcnt <= clr ? 0 : vcnt + int'(vsync_out && !v_q);
  end
endmodule

// [bench/display_power_sync_gating_tb.sv]
// testbench for the display power and sync gating block
`timescale 1ns/1ps
`include "dpsg_defs.vh"
module display_power_sync_gating_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ref_clk = 0, drst_n = 0, clr = 0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, pslverr, hs, vs, pt;
  wire [3:0] oe;
  int hc, vc, i, error_cnt = 0, n_tests = 0;
  initial forever #5 pclk = ~pclk;
  initial forever #10.417 ref_clk = ~ref_clk;
  dpsg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .display_reference_clock(ref_clk), .disp_rst_n(drst_n),
    .hsync_out(hs), .vsync_out(vs), .out_enable(oe), .pix_tick(pt));
  dpsg_mon u_mon (.clk(ref_clk), .clr(clr), .hsync_out(hs), .vsync_out(vs),
    .hcnt(hc), .vcnt(vc));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    chk(err, e);
  endtask
  task sync_chk(input logic eh, input logic ev);
    repeat (400) @(posedge pclk);
    clr <= 1;
    repeat (3) @(posedge pclk);
    clr <= 0;
    repeat (400) @(posedge pclk);
    chk(hc != 0, eh);
    chk(vc != 0, ev);
  endtask
  task give_verdict;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task t_reset;
    apb(0, `DPSG_CTRL_OFF, 0, 0);
    chk(rd, `DPSG_CTRL_RESET);
    apb(0, `DPSG_ROUTE_OFF, 0, 0);
    chk(rd, `DPSG_ROUTE_RESET);
    apb(0, 12'h020, 0, 1);
    chk(rd, 32'h0);
    $display("t_reset done");
  endtask
  task t_route;
    apb(1, `DPSG_TIMING_OFF, 32'h0002_000a, 0);
    apb(1, `DPSG_PIXDIV_OFF, 32'h1004_0001, 0);
    apb(1, `DPSG_ROUTE_OFF, 32'h3, 0);
    apb(1, `DPSG_ROUTE_OFF, 32'h33, 1);
    apb(1, `DPSG_ROUTE_OFF, 32'h103, 1);
    apb(1, `DPSG_ROUTE_OFF, 32'h7, 1);
    apb(0, `DPSG_ROUTE_OFF, 0, 0);
    chk(rd, 32'h3);
    apb(0, `DPSG_STAT_OFF, 0, 0);
    chk(rd[8], 1);
    repeat (400) @(posedge pclk);
    chk(oe, 32'h3);
    chk(pt, 1);
    $display("t_route done");
  endtask
  task t_mon;
    for (i = 0; i < 4; i++) begin
      apb(1, `DPSG_CTRL_OFF, i, 0);
      sync_chk(!i[0], !i[1]);
    end
    $display("t_mon done");
  endtask
  task t_gfx;
    apb(1, `DPSG_CTRL_OFF, 32'h4, 0);
    sync_chk(0, 0);
    chk(oe, 32'h0);
    apb(1, `DPSG_CTRL_OFF, 32'h0, 0);
    sync_chk(1, 1);
    $display("t_gfx done");
  endtask
  initial begin
    #200000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    drst_n <= 1;
    t_reset;
    t_route;
    t_mon;
    t_gfx;
    give_verdict;
  end
endmodule
